//--- fan_speed_monitor_defines.vh
// Register map, field positions and timing counts for the fan speed monitor
`ifndef FAN_SPEED_MONITOR_DEFINES_VH
`define FAN_SPEED_MONITOR_DEFINES_VH

// -----------------------------------------------------------------
// Register offsets
// -----------------------------------------------------------------
`define OFS_CONTROL        4'h0
`define OFS_STATUS         4'h4
`define OFS_UPPER          4'h8
`define OFS_LOWER          4'hC

// -----------------------------------------------------------------
// Control fields
// -----------------------------------------------------------------
`define CTL_ENABLE_BIT     0
`define CTL_MODE_BIT       10
`define CTL_EDGES_LSB      11
`define CTL_DONE_IE_BIT    14
`define CTL_TOGGLE_IE_BIT  15
`define CTL_LIMIT_IE_BIT   8
`define CTL_WMASK          16'hDD01

// -----------------------------------------------------------------
// Status fields
// -----------------------------------------------------------------
`define STS_LIMIT_BIT      0
`define STS_PIN_BIT        1
`define STS_TOGGLE_BIT     2
`define STS_DONE_BIT       3

// -----------------------------------------------------------------
// Reset values and timing
// -----------------------------------------------------------------
`define CONTROL_RESET      16'h0000
`define LIMIT_RESET        16'h0000
`define UPPER_RESET        16'hFFFF
`define COUNT_MAX          16'hFFFF
`define SYS_CLK_HZ         100000000
`define REF_CLK_HZ         100000
`define REF_DIV            (`SYS_CLK_HZ / `REF_CLK_HZ)

`endif

//--- pulse_edge_detect.v
// Input synchroniser and edge detector for the fan pulse pin
`timescale 1ns/10ps
module pulse_edge_detect (
	input  wire sys_clk,
	input  wire rst,
	input  wire pin_in,
	output reg  pin_level,
	output wire rise,
	output wire any_edge
);
	reg meta;
	reg last;

	// ------------------------------------------------------------
	// Two-stage synchroniser and edge detect
	// ------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta      <= 1'b0;
			pin_level <= 1'b0;
			last      <= 1'b0;
		end else begin
			meta      <= pin_in;
			pin_level <= meta;
			last      <= pin_level;
		end
	end

	assign rise     = pin_level & ~last;
	assign any_edge = pin_level ^ last;
endmodule // pulse_edge_detect

//--- ref_tick_gen.v
// Divider making the 100 kHz reference tick from the system clock
`timescale 1ns/10ps
`include "fan_speed_monitor_defines.vh"
module ref_tick_gen (
	input  wire sys_clk,
	input  wire rst,
	input  wire run,
	output reg  tick
);
	localparam integer DIV_LAST_INT = `REF_DIV - 1;
	localparam [15:0]  DIV_LAST     = DIV_LAST_INT[15:0];
	reg [15:0] div_count;

	// ------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			div_count <= 16'h0000;
			tick      <= 1'b0;
		end else if (!run) begin
			div_count <= 16'h0000;
			tick      <= 1'b0;
		end else if (div_count == DIV_LAST) begin
			div_count <= 16'h0000;
			tick      <= 1'b1;
		end else begin
			div_count <= div_count + 16'h0001;
			tick      <= 1'b0;
		end
	end
endmodule // ref_tick_gen

//--- fan_speed_monitor.v
// Fan speed monitor with AXI4-Lite register slave
// Functional notes
// - Mode 0 counts rising edges of pin
// - Mode 0 counter wraps to zero, continues
// - Mode 1 counts reference ticks over edges
// - Mode 1 latches reading, sets done flag
// - Done flag with enable raises interrupt
// - Reading outside limits sets violation flag
// - Violation flag with enable raises interrupt
// - Interrupt is OR of status events
// - Reset returns everything to default
// - Two modes chosen by mode bit
// - Accepts low-power request from power control
// - Measures 100 to 30000 RPM
// - Registers at 00h 04h 08h 0Ch
// - Edge select 2, 3, 5, 9 edges
// - Mode 1 latches at all-ones, then clears
`timescale 1ns/10ps
`include "fan_speed_monitor_defines.vh"
module fan_speed_monitor (
	input  wire        sys_clk,
	input  wire        rst,
	input  wire        fan_pulse_input,
	input  wire        sleep_request,
	output wire        sleep_ack,
	output reg         speed_monitor_irq,
	input  wire [3:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [3:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	localparam MODE_FREE = 1'b0;
	localparam MODE_REF  = 1'b1;

	// ------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------
	function [3:0] edges_for;
		input [1:0] sel;
		begin
			case (sel)
				2'h0:    edges_for = 4'h2;
				2'h1:    edges_for = 4'h3;
				2'h2:    edges_for = 4'h5;
				default: edges_for = 4'h9;
			endcase
		end
	endfunction

	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0]  strb;
		integer i;
		begin
			merge_bytes = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (strb[i])
					merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
	endfunction

	// ------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------
	reg  [15:0] control_bits;
	reg  [15:0] pulse_count_reading;
	reg  [15:0] counter;
	reg  [3:0]  edges_seen;
	reg  [15:0] upper_bound;
	reg  [15:0] lower_bound;
	reg         speed_limit_violation_flag;
	reg         measurement_done_flag;
	reg         toggle_flag;
	reg         sleep_state;
	reg         aw_held;
	reg         w_held;
	reg  [3:0]  aw_addr;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	reg         next_violation;
	reg         next_done;
	reg  [15:0] next_reading;
	reg         latch_now;

	wire        pin_level;
	wire        pin_rise;
	wire        pin_edge;
	wire        ref_tick;
	wire        fan_speed_monitor_enable = control_bits[`CTL_ENABLE_BIT];
	wire        measure_mode_select      = control_bits[`CTL_MODE_BIT];
	wire [1:0]  edge_count_select        = control_bits[`CTL_EDGES_LSB +: 2];
	wire        measurement_done_irq_en  = control_bits[`CTL_DONE_IE_BIT];
	wire        toggle_irq_en            = control_bits[`CTL_TOGGLE_IE_BIT];
	wire        limit_irq_en             = control_bits[`CTL_LIMIT_IE_BIT];
	wire        active = fan_speed_monitor_enable & ~sleep_state;
	wire [3:0]  edge_target = edges_for(edge_count_select);
	wire        do_write = aw_held & w_held & ~s_axi_bvalid;
	wire [31:0] wr_merged_ctl = merge_bytes({pulse_count_reading, control_bits}, w_data, w_strb);
	wire [31:0] wr_merged_up  = merge_bytes({16'h0000, upper_bound}, w_data, w_strb);
	wire [31:0] wr_merged_lo  = merge_bytes({16'h0000, lower_bound}, w_data, w_strb);

	// ------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------
	pulse_edge_detect u_edge (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.pin_in    (fan_pulse_input),
		.pin_level (pin_level),
		.rise      (pin_rise),
		.any_edge  (pin_edge)
	);

	ref_tick_gen u_tick (
		.sys_clk (sys_clk),
		.rst     (rst),
		.run     (active),
		.tick    (ref_tick)
	);

	assign sleep_ack = sleep_state;

	// ------------------------------------------------------------
	// Measurement
	// ------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			counter     <= 16'h0000;
			edges_seen  <= 4'h0;
			sleep_state <= 1'b0;
		end else begin
			sleep_state <= sleep_request;
			if (!active) begin
				edges_seen <= 4'h0;
				if (measure_mode_select == MODE_REF)
					counter <= 16'h0000;
			end else begin
				case (measure_mode_select)
					MODE_FREE: begin
						edges_seen <= 4'h0;
						if (pin_rise)
							counter <= counter + 16'h0001;
					end
					MODE_REF: begin
						if (latch_now) begin
							counter    <= 16'h0000;
							edges_seen <= {3'h0, pin_edge};
						end else begin
							if (ref_tick)
								counter <= counter + 16'h0001;
							if (pin_edge)
								edges_seen <= edges_seen + 4'h1;
						end
					end
					default: counter <= counter;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// Latch, flags and limits
	// ------------------------------------------------------------
	always @* begin
		latch_now    = 1'b0;
		next_reading = pulse_count_reading;
		if (active && measure_mode_select == MODE_FREE) begin
			next_reading = counter;
		end else if (active && measure_mode_select == MODE_REF) begin
			if (pin_edge && (edges_seen + 4'h1 >= edge_target))
				latch_now = 1'b1;
			if (counter == `COUNT_MAX)
				latch_now = 1'b1;
			if (latch_now)
				next_reading = counter;
		end
		next_done      = measurement_done_flag;
		next_violation = speed_limit_violation_flag;
		if (do_write && aw_addr == `OFS_STATUS && w_strb[0]) begin
			if (w_data[`STS_DONE_BIT])
				next_done = 1'b0;
			if (w_data[`STS_LIMIT_BIT])
				next_violation = 1'b0;
		end
		if (latch_now)
			next_done = 1'b1;
		if (active && (pulse_count_reading > upper_bound || pulse_count_reading < lower_bound))
			next_violation = 1'b1;
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pulse_count_reading        <= 16'h0000;
			measurement_done_flag      <= 1'b0;
			speed_limit_violation_flag <= 1'b0;
			toggle_flag                <= 1'b0;
			speed_monitor_irq          <= 1'b0;
		end else begin
			pulse_count_reading        <= next_reading;
			measurement_done_flag      <= next_done;
			speed_limit_violation_flag <= next_violation;
			if (active && pin_edge)
				toggle_flag <= 1'b1;
			else if (do_write && aw_addr == `OFS_STATUS && w_strb[0] && w_data[`STS_TOGGLE_BIT])
				toggle_flag <= 1'b0;
			speed_monitor_irq <= (measurement_done_flag & measurement_done_irq_en)
				| (speed_limit_violation_flag & limit_irq_en)
				| (toggle_flag & toggle_irq_en);
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite write
	// ------------------------------------------------------------
	assign s_axi_awready = ~aw_held;
	assign s_axi_wready  = ~w_held;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 4'h0;
			w_data       <= 32'h00000000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
			control_bits <= `CONTROL_RESET;
			upper_bound  <= `UPPER_RESET;
			lower_bound  <= `LIMIT_RESET;
		end else begin
			if (s_axi_awvalid && !aw_held) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_held) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (do_write) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= 2'h0;
				case ({aw_addr[3:2], 2'b00})
					`OFS_CONTROL: control_bits <= wr_merged_ctl[15:0] & `CTL_WMASK;
					`OFS_STATUS:  s_axi_bresp  <= 2'h0;
					`OFS_UPPER:   upper_bound  <= wr_merged_up[15:0];
					`OFS_LOWER:   lower_bound  <= wr_merged_lo[15:0];
					default:      s_axi_bresp  <= 2'h2;
				endcase
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read
	// ------------------------------------------------------------
	assign s_axi_arready = ~s_axi_rvalid;

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'h0;
		end else begin
			if (s_axi_arvalid && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= 2'h0;
				case ({s_axi_araddr[3:2], 2'b00})
					`OFS_CONTROL: s_axi_rdata <= {pulse_count_reading, control_bits};
					`OFS_STATUS:  s_axi_rdata <= {28'h0000000, measurement_done_flag, toggle_flag,
						pin_level, speed_limit_violation_flag};
					`OFS_UPPER:   s_axi_rdata <= {16'h0000, upper_bound};
					`OFS_LOWER:   s_axi_rdata <= {16'h0000, lower_bound};
					default:      s_axi_rdata <= 32'h00000000;
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // fan_speed_monitor

//--- fan_tach_model.sv
// Fan tachometer model: square wave with programmable half period
`timescale 1ns/10ps
module fan_tach_model (
	input  wire        sys_clk,
	input  wire        run,
	input  wire [15:0] half,
	output reg         tach = 1'b0
);
	reg [15:0] cnt = 16'h0000;

	// Stopped fan holds its last level
	always @(posedge sys_clk) begin
		if (run) begin
			if (cnt >= half - 16'h0001) begin
				cnt <= 16'h0000;
				tach <= ~tach;
			end else
				cnt <= cnt + 16'h0001;
		end
	end
endmodule // fan_tach_model

//--- fan_speed_monitor_props.sv
// Port checks for the fan speed monitor
`timescale 1ns/10ps
module fan_speed_monitor_props (
	input wire       sys_clk,
	input wire       rst,
	input wire       sleep_request,
	input wire       sleep_ack,
	input wire       speed_monitor_irq,
	input wire       s_axi_awvalid,
	input wire       s_axi_awready,
	input wire       s_axi_wvalid,
	input wire       s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire       s_axi_bvalid,
	input wire       s_axi_bready,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	input wire       s_axi_rready
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// -------------------------------------------------
	// Properties
	// -------------------------------------------------
	property p_sleep_on; $rose(sleep_request) |=> sleep_ack; endproperty
	a_sleep_on: assert property (p_sleep_on) else $error("sleep ack late");
	property p_sleep_off; $fell(sleep_request) |=> !sleep_ack; endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("sleep ack stuck");
	property p_rst_quiet; $fell(rst) |-> !speed_monitor_irq && !s_axi_bvalid && !s_axi_rvalid; endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not idle after reset");
	property p_b_resp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_b_resp: assert property (p_b_resp) else $error("no write response");
	property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_b_done: assert property (p_b_done) else $error("bvalid after handshake");
	property p_aw_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_aw_block: assert property (p_aw_block) else $error("write taken before response");
	property p_okay; s_axi_bvalid |-> s_axi_bresp == 2'h0; endproperty
	a_okay: assert property (p_okay) else $error("write response not okay");
	property p_r_resp; s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid; endproperty
	a_r_resp: assert property (p_r_resp) else $error("no read data");
	property p_r_done; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_r_done: assert property (p_r_done) else $error("rvalid after handshake");
	property p_ar_block; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken while busy");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
	c_irq: cover property ($rose(speed_monitor_irq));
	c_sleep: cover property ($rose(sleep_ack));
endmodule // fan_speed_monitor_props

bind fan_speed_monitor fan_speed_monitor_props u_props (
	.sys_clk(sys_clk), .rst(rst), .sleep_request(sleep_request), .sleep_ack(sleep_ack),
	.speed_monitor_irq(speed_monitor_irq), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

//--- fan_speed_monitor_tb_top.sv
// Self-checking testbench for the fan speed monitor
`timescale 1ns/10ps
`include "fan_speed_monitor_defines.vh"
module fan_speed_monitor_tb_top;
	reg         sys_clk = 1'b0, rst = 1'b1, fan_run = 1'b0, sleep_request = 1'b0;
	reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	reg  [15:0] half = 16'h0004;
	reg  [3:0]  awaddr = 4'h0, araddr = 4'h0;
	reg  [31:0] wdata = 32'h0, r;
	reg  [68:0] rows [0:7];
	wire        fan, sleep_ack, irq, awready, wready, bvalid, arready, rvalid;
	wire [1:0]  bresp, rresp;
	wire [31:0] rdata;
	integer     bad_count = 0, num_checks = 0, i, n;

	always #5 sys_clk = ~sys_clk;

	fan_tach_model fan_model (.sys_clk(sys_clk), .run(fan_run), .half(half), .tach(fan));
	fan_speed_monitor dut (
		.sys_clk(sys_clk), .rst(rst), .fan_pulse_input(fan), .sleep_request(sleep_request),
		.sleep_ack(sleep_ack), .speed_monitor_irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
	);
	// -------------------------------------------------
	// Bus tasks and checks
	// -------------------------------------------------
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			@(posedge sys_clk);
			while (bvalid !== 1'b1) begin
				if (awready === 1'b1) awvalid <= 1'b0;
				if (wready === 1'b1) wvalid <= 1'b0;
				@(posedge sys_clk);
			end
			bready <= 1'b0;
		end
	endtask
	task rd(input [3:0] a, output [31:0] d);
		begin
			@(posedge sys_clk);
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			@(posedge sys_clk);
			while (rvalid !== 1'b1) begin
				if (arready === 1'b1) arvalid <= 1'b0;
				@(posedge sys_clk);
			end
			d = rdata;
			rready <= 1'b0;
		end
	endtask
	task chk(input [31:0] got, input [31:0] lo, input [31:0] hi);
		begin
			num_checks = num_checks + 1;
			if ((got >= lo && got <= hi) !== 1'b1) begin
				bad_count = bad_count + 1;
				$display("unexpected at %0t got %h exp %h", $time, got, lo);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	// -------------------------------------------------
	// Tests
	// -------------------------------------------------
	initial begin
		rows[0] = {1'b0, `OFS_CONTROL, 32'h0, 32'h0};
		rows[1] = {1'b0, `OFS_STATUS, 32'h0, 32'h0};
		rows[2] = {1'b0, `OFS_UPPER, 32'h0, 32'hFFFF};
		rows[3] = {1'b0, `OFS_LOWER, 32'h0, 32'h0};
		rows[4] = {1'b1, `OFS_UPPER, 32'hFFFF1234, 32'h1234};
		rows[5] = {1'b1, `OFS_LOWER, 32'hFFFF0000, 32'h0};
		rows[6] = {1'b1, `OFS_CONTROL, 32'hFFFFFFFE, 32'hDD00};
		rows[7] = {1'b1, `OFS_CONTROL, 32'h0, 32'h0};
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		for (i = 0; i < 8; i = i + 1) begin
			if (rows[i][68])
				wr(rows[i][67:64], rows[i][63:32]);
			rd(rows[i][67:64], r);
			chk(r, rows[i][31:0], rows[i][31:0]);
		end
		$display("registers done");
		rd(`OFS_CONTROL, r);
		n = r[31:16];
		wr(`OFS_CONTROL, 32'h1);
		fan_run <= 1'b1;
		repeat (10) @(posedge fan);
		fan_run <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(`OFS_CONTROL, r);
		chk(r[31:16] - n[15:0], 32'hA, 32'hA);
		wr(`OFS_CONTROL, 32'h0);
		fan_run <= 1'b1;
		repeat (4) @(posedge fan);
		fan_run <= 1'b0;
		repeat (8) @(posedge sys_clk);
		rd(`OFS_CONTROL, r);
		chk(r[31:16], 32'hA, 32'hA);
		$display("mode 0 done");
		half <= 16'h03E8;
		fan_run <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			n = (i == 0) ? 2 : (i == 1) ? 3 : (i == 2) ? 5 : 9;
			wr(`OFS_CONTROL, 32'h4401 | (i << 11));
			while (irq !== 1'b1) @(posedge sys_clk);
			wr(`OFS_STATUS, 32'h8);
			repeat (2) @(posedge sys_clk);
			chk(irq, 32'h0, 32'h0);
			while (irq !== 1'b1) @(posedge sys_clk);
			rd(`OFS_STATUS, r);
			chk(r[3], 32'h1, 32'h1);
			rd(`OFS_CONTROL, r);
			chk(r[31:16], n - 2, n - 1);
			wr(`OFS_STATUS, 32'h8);
		end
		$display("mode 1 done");
		wr(`OFS_CONTROL, 32'h1D01);
		for (i = 0; i < 2; i = i + 1) begin
			wr(`OFS_STATUS, 32'h1);
			wr(i ? `OFS_LOWER : `OFS_UPPER, i ? 32'h100 : 32'h2);
			while (irq !== 1'b1) @(posedge sys_clk);
			rd(`OFS_STATUS, r);
			chk(r[0], 32'h1, 32'h1);
			wr(i ? `OFS_LOWER : `OFS_UPPER, i ? 32'h0 : 32'hFFFF);
		end
		wr(`OFS_STATUS, 32'h1);
		repeat (2) @(posedge sys_clk);
		chk(irq, 32'h0, 32'h0);
		$display("limits done");
		sleep_request <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(sleep_ack, 32'h1, 32'h1);
		sleep_request <= 1'b0;
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`OFS_UPPER, r);
		chk(r, 32'hFFFF, 32'hFFFF);
		rd(`OFS_CONTROL, r);
		chk(r, 32'h0, 32'h0);
		$display("sleep and reset done");
		final_report;
	end

	initial begin
		#1000000;
		bad_count = bad_count + 1;
		final_report;
	end
endmodule // fan_speed_monitor_tb_top
